// *** rxc_defs.svh ***
`ifndef RXC_DEFS_SVH
`define RXC_DEFS_SVH

// Register addresses on the serial programming port
`define RXC_ADDR_MAIN          7'h00
`define RXC_ADDR_MODF          7'h01
`define RXC_ADDR_FCLK          7'h08
`define RXC_ADDR_ESTC          7'h15
`define RXC_ADDR_ESTR          7'h16

// Reset values
`define RXC_RST_MAIN           8'h00
`define RXC_RST_MODF           8'h00
`define RXC_RST_FCLK           8'h84
`define RXC_RST_ESTC           4'h0
`define RXC_RST_ESTR           8'h00

// Field positions
`define RXC_MAIN_AMP_BYP       7
`define RXC_MAIN_MODE_HI       2
`define RXC_MAIN_MODE_LO       1
`define RXC_MODF_LEVEL_EN      3
`define RXC_MODF_CORNER_HI     1
`define RXC_MODF_CORNER_LO     0
`define RXC_FCLK_DOUBLE        6
`define RXC_FCLK_DIV_HI        5
`define RXC_FCLK_DIV_LO        0
`define RXC_ESTC_MODE_HI       1
`define RXC_ESTC_MODE_LO       0
`define RXC_ESTC_LEN_HI        3
`define RXC_ESTC_LEN_LO        2

// Transceiver mode code for receive
`define RXC_MODE_RECEIVE       2'h2

// Measurement lengths in symbols
`define RXC_LEN_CODE0          7'h08
`define RXC_LEN_CODE1          7'h10
`define RXC_LEN_CODE2          7'h20
`define RXC_LEN_CODE3          7'h40

// Serial frame: 7 address bits, 1 read flag, 8 data bits
`define RXC_FRAME_BITS         16
`define RXC_HDR_LAST           4'h7
`define RXC_FRAME_LAST         4'hF

// Filter clock fixed phase division
`define RXC_PHASES             4
`define RXC_PHASE_RST          4'h1

`endif

// *** rxc_filter_clk_div.sv ***
`timescale 1ns/10ps
`include "rxc_defs.svh"

module rxc_filter_clk_div #(
   parameter int DIV_W = 6
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_resetn,
   input  wire logic [DIV_W-1:0] i_div,
   output logic [3:0]            o_phase,
   output logic                  o_filter_clk
);
   import rxc_pkg::*;

   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] div_eff;
   logic             tick;

   // Zero would stall the filter clock, so it acts as one
   assign div_eff = (i_div == '0) ? DIV_W'(1) : i_div;
   assign tick    = (cnt_r >= div_eff - DIV_W'(1));

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_r <= '0;
      end else if (tick) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + DIV_W'(1);
      end
   end

   // Rotating one-hot gives four non-overlapping phases
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_phase <= `RXC_PHASE_RST;
      end else if (tick) begin
         o_phase <= {o_phase[2:0], o_phase[3]};
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_filter_clk <= 1'b0;
      end else if (tick) begin
         o_filter_clk <= ~o_filter_clk;
      end
   end

   chk_phase_one_hot: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      $onehot(o_phase))
      else $error("filter phases not one-hot");

   chk_tick_spacing: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (tick && $stable(i_div) && $past(tick)) |-> (div_eff == DIV_W'(1)))
      else $error("divider ticks too close");

   chk_filter_clk_toggle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      tick |=> (o_filter_clk != $past(o_filter_clk)) && (o_phase != $past(o_phase)))
      else $error("filter clock did not advance on tick");

endmodule // rxc_filter_clk_div

// *** rxc_host_model.sv ***
`timescale 1ns/10ps
`include "rxc_defs.svh"

module rxc_host_model (
   input  wire logic i_ref_clk,
   input  wire logic i_prog_data,
   output logic      o_prog_clk,
   output logic      o_prog_enable,
   output logic      o_prog_data
);
   // Levels held well above the three-clock sync need
   localparam int HOLD = 6;

   initial begin
      o_prog_clk    = 1'b0;
      o_prog_enable = 1'b0;
      o_prog_data   = 1'b0;
   end

   task automatic frame(input logic [6:0] addr, input logic rd, input logic [7:0] wdata,
                        output logic [7:0] rdata);
      logic [15:0] bits;
      bits  = {addr, rd, wdata};
      rdata = 8'h00;
      @(negedge i_ref_clk);
      o_prog_enable = 1'b1;
      for (int k = 15; k >= 0; k--) begin
         o_prog_clk = 1'b0;
         // Released line toggles so a stale level never passes for data
         o_prog_data = (rd && k < 8) ? ~o_prog_data : bits[k];
         repeat (HOLD) @(negedge i_ref_clk);
         if (rd && k < 8) begin
            rdata[k] = i_prog_data;
         end
         o_prog_clk = 1'b1;
         repeat (HOLD) @(negedge i_ref_clk);
      end
      o_prog_clk = 1'b0;
      repeat (HOLD) @(negedge i_ref_clk);
      o_prog_enable = 1'b0;
      repeat (HOLD) @(negedge i_ref_clk);
   endtask

   task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
      logic [7:0] d;
      logic [7:0] unused;
      d = data;
      if (addr == `RXC_ADDR_FCLK) begin
         d = {1'b1, d[6], 1'b0, d[4:0]};
      end
      frame(addr, 1'b0, d, unused);
   endtask

   task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
      frame(addr, 1'b1, 8'h00, data);
   endtask
endmodule // rxc_host_model

// *** rxc_pkg.sv ***
package rxc_pkg;

   typedef enum logic [1:0] {
      RXC_EST_OFF,
      RXC_EST_UP,
      RXC_EST_DOWN,
      RXC_EST_BOTH
   } rxc_est_mode_type;

   typedef enum logic {
      RXC_ST_IDLE,
      RXC_ST_COUNT
   } rxc_est_state_type;

   typedef struct packed {
      logic       front_amp_bypass;
      logic [1:0] prefilter_corner_sel;
      logic       signal_level_enable;
      logic       filter_clock_double;
   } rxc_rx_cfg_type;

   typedef struct packed {
      logic bit_val;
      logic up_pulse;
      logic down_pulse;
   } rxc_demod_type;

endpackage

// *** rxc_top.sv ***
`timescale 1ns/10ps
`include "rxc_defs.svh"

module rxc_top #(
   parameter int NSYNC = 6
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_resetn,
   input  wire logic              i_prog_clk,
   input  wire logic              i_prog_enable,
   input  wire logic              i_prog_data,
   output logic                   o_prog_data,
   output logic                   o_prog_data_oe_n,
   input  wire logic              i_ichan,
   input  wire logic              i_qchan,
   input  wire logic              i_symbol_strobe,
   input  wire logic              i_bidir_data_pin,
   output logic                   o_bidir_data_pin,
   output logic                   o_bidir_data_pin_oe_n,
   output logic                   o_tx_data,
   output logic [1:0]             o_xcvr_mode,
   output rxc_pkg::rxc_rx_cfg_type o_rx_cfg,
   output logic [3:0]             o_filter_phase,
   output logic                   o_filter_clk
);
   import rxc_pkg::*;

   function automatic logic [6:0] len_of(input logic [1:0] code);
      case (code)
         2'h0:    len_of = `RXC_LEN_CODE0;
         2'h1:    len_of = `RXC_LEN_CODE1;
         2'h2:    len_of = `RXC_LEN_CODE2;
         default: len_of = `RXC_LEN_CODE3;
      endcase
   endfunction

   // Saturation keeps up-only results from wrapping negative
   function automatic logic [7:0] sat_step(input logic [7:0] v, input logic up, input logic down);
      if (up && v != 8'h7F) begin
         sat_step = v + 8'h01;
      end else if (down && v != 8'h80) begin
         sat_step = v - 8'h01;
      end else begin
         sat_step = v;
      end
   endfunction

   logic [NSYNC-1:0]  sync_in;
   logic [NSYNC-1:0]  s1_r;
   logic [NSYNC-1:0]  s2_r;
   logic              pclk_prev_r;
   logic              ich_prev_r;
   logic              pclk_s;
   logic              pen_s;
   logic              pdat_s;
   logic              ich_s;
   logic              qch_s;
   logic              prog_rise;
   logic              prog_fall;
   logic              i_rise;
   logic [3:0]        bit_cnt_r;
   logic [14:0]       shift_r;
   logic [7:0]        rd_sr_r;
   logic              rd_active_r;
   logic              wr_stb;
   logic [6:0]        wr_addr;
   logic [7:0]        wr_data;
   logic [7:0]        main_r;
   logic [7:0]        modf_r;
   logic [7:0]        fclk_r;
   logic [3:0]        estc_r;
   logic [7:0]        result_r;
   logic              est_restart;
   logic              rx_mode;
   rxc_est_mode_type  est_mode;
   rxc_est_state_type state_r;
   rxc_demod_type     demod_r;
   logic              active;
   logic              count_up;
   logic              count_down;
   logic [7:0]        count_r;
   logic [7:0]        count_nxt;
   logic [6:0]        sym_cnt_r;
   logic              done;

   assign sync_in = {i_prog_clk, i_prog_enable, i_prog_data, i_ichan, i_qchan, i_bidir_data_pin};

   genvar k;
   generate
      for (k = 0; k < NSYNC; k++) begin : g_sync
         always_ff @(posedge i_ref_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               s1_r[k] <= 1'b0;
               s2_r[k] <= 1'b0;
            end else begin
               s1_r[k] <= sync_in[k];
               s2_r[k] <= s1_r[k];
            end
         end
      end
   endgenerate

   assign pclk_s    = s2_r[5];
   assign pen_s     = s2_r[4];
   assign pdat_s    = s2_r[3];
   assign ich_s     = s2_r[2];
   assign qch_s     = s2_r[1];
   assign o_tx_data = s2_r[0];

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pclk_prev_r <= 1'b0;
         ich_prev_r  <= 1'b0;
      end else begin
         pclk_prev_r <= pclk_s;
         ich_prev_r  <= ich_s;
      end
   end

   assign prog_rise = pen_s && pclk_s && !pclk_prev_r;
   assign prog_fall = pen_s && !pclk_s && pclk_prev_r;
   assign i_rise    = ich_s && !ich_prev_r;

   // Serial programming port: address, read flag, data, MSB first
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bit_cnt_r <= 4'h0;
         shift_r   <= 15'h0000;
      end else if (!pen_s) begin
         bit_cnt_r <= 4'h0;
      end else if (prog_rise) begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
         shift_r   <= {shift_r[13:0], pdat_s};
      end
   end

   assign wr_stb  = prog_rise && (bit_cnt_r == `RXC_FRAME_LAST) && !shift_r[7];
   assign wr_addr = shift_r[14:8];
   assign wr_data = {shift_r[6:0], pdat_s};

   function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] m, input logic [7:0] f,
                                           input logic [7:0] c, input logic [3:0] e, input logic [7:0] r);
      case (a)
         `RXC_ADDR_MAIN: reg_read = m;
         `RXC_ADDR_MODF: reg_read = f;
         `RXC_ADDR_FCLK: reg_read = c;
         `RXC_ADDR_ESTC: reg_read = {4'h0, e};
         `RXC_ADDR_ESTR: reg_read = r;
         default:        reg_read = 8'h00;
      endcase
   endfunction

   // Read data changes on falling edges so the host samples on rising
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_active_r <= 1'b0;
         rd_sr_r     <= 8'h00;
         o_prog_data <= 1'b0;
      end else if (!pen_s) begin
         rd_active_r <= 1'b0;
      end else if (prog_rise && bit_cnt_r == `RXC_HDR_LAST && pdat_s) begin
         rd_active_r <= 1'b1;
         rd_sr_r     <= reg_read(shift_r[6:0], main_r, modf_r, fclk_r, estc_r, result_r);
      end else if (prog_fall && rd_active_r) begin
         o_prog_data <= rd_sr_r[7];
         rd_sr_r     <= {rd_sr_r[6:0], 1'b0};
      end
   end

   assign o_prog_data_oe_n = !(rd_active_r && pen_s);

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         main_r <= `RXC_RST_MAIN;
         modf_r <= `RXC_RST_MODF;
         fclk_r <= `RXC_RST_FCLK;
         estc_r <= `RXC_RST_ESTC;
      end else if (wr_stb) begin
         case (wr_addr)
            `RXC_ADDR_MAIN: main_r <= wr_data;
            `RXC_ADDR_MODF: modf_r <= wr_data;
            `RXC_ADDR_FCLK: fclk_r <= wr_data;
            `RXC_ADDR_ESTC: estc_r <= wr_data[3:0];
            default:        ;
         endcase
      end
   end

   assign est_restart = wr_stb && (wr_addr == `RXC_ADDR_ESTC);

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rx_cfg <= '0;
      end else begin
         o_rx_cfg.front_amp_bypass     <= main_r[`RXC_MAIN_AMP_BYP];
         o_rx_cfg.prefilter_corner_sel <= modf_r[`RXC_MODF_CORNER_HI:`RXC_MODF_CORNER_LO];
         o_rx_cfg.signal_level_enable  <= modf_r[`RXC_MODF_LEVEL_EN];
         o_rx_cfg.filter_clock_double  <= fclk_r[`RXC_FCLK_DOUBLE];
      end
   end

   assign o_xcvr_mode = main_r[`RXC_MAIN_MODE_HI:`RXC_MAIN_MODE_LO];
   assign rx_mode     = (o_xcvr_mode == `RXC_MODE_RECEIVE);

   rxc_filter_clk_div #(
      .DIV_W (6)
   ) u_fdiv (
      .i_ref_clk    (i_ref_clk),
      .i_resetn     (i_resetn),
      .i_div        (fclk_r[`RXC_FCLK_DIV_HI:`RXC_FCLK_DIV_LO]),
      .o_phase      (o_filter_phase),
      .o_filter_clk (o_filter_clk)
   );

   // Q already high at I rising edge means I lags Q
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         demod_r <= '0;
      end else begin
         demod_r.up_pulse   <= i_rise && qch_s;
         demod_r.down_pulse <= i_rise && !qch_s;
         if (i_rise) begin
            demod_r.bit_val <= qch_s;
         end
      end
   end

   assign o_bidir_data_pin      = demod_r.bit_val;
   assign o_bidir_data_pin_oe_n = !rx_mode;

   assign est_mode   = rxc_est_mode_type'(estc_r[`RXC_ESTC_MODE_HI:`RXC_ESTC_MODE_LO]);
   assign active     = rx_mode && (est_mode != RXC_EST_OFF);
   assign count_up   = demod_r.up_pulse && (est_mode == RXC_EST_UP || est_mode == RXC_EST_BOTH);
   assign count_down = demod_r.down_pulse && (est_mode == RXC_EST_DOWN || est_mode == RXC_EST_BOTH);

   // Down-only mode counts toward negative, stored two's complement
   assign count_nxt = sat_step(count_r, count_up, count_down);
   assign done      = (state_r == RXC_ST_COUNT) && i_symbol_strobe &&
                      (sym_cnt_r == len_of(estc_r[`RXC_ESTC_LEN_HI:`RXC_ESTC_LEN_LO]) - 7'h01);

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_r <= RXC_ST_IDLE;
      end else if (!active || est_restart) begin
         state_r <= RXC_ST_IDLE;
      end else begin
         case (state_r)
            RXC_ST_IDLE:  state_r <= RXC_ST_COUNT;
            RXC_ST_COUNT: state_r <= done ? RXC_ST_IDLE : RXC_ST_COUNT;
            default:      state_r <= RXC_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         count_r   <= 8'h00;
         sym_cnt_r <= 7'h00;
      end else if (state_r == RXC_ST_IDLE) begin
         count_r   <= 8'h00;
         sym_cnt_r <= 7'h00;
      end else begin
         count_r <= count_nxt;
         if (i_symbol_strobe) begin
            sym_cnt_r <= sym_cnt_r + 7'h01;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         result_r <= `RXC_RST_ESTR;
      end else if (done && active && !est_restart) begin
         result_r <= count_nxt;
      end
   end

   chk_amp_bypass_map: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      ##1 o_rx_cfg.front_amp_bypass == $past(main_r[`RXC_MAIN_AMP_BYP]))
      else $error("amplifier bypass not following register");

   chk_corner_sel_map: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      ##1 o_rx_cfg.prefilter_corner_sel == $past(modf_r[`RXC_MODF_CORNER_HI:`RXC_MODF_CORNER_LO]))
      else $error("prefilter corner select wrong");

   sequence s_edge_q_high;
      i_rise && qch_s;
   endsequence

   chk_decide_one: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      s_edge_q_high |=> demod_r.bit_val && demod_r.up_pulse && !demod_r.down_pulse)
      else $error("lagging I not decided as one");

   chk_decide_zero: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (i_rise && !qch_s) |=> !demod_r.bit_val && demod_r.down_pulse && !demod_r.up_pulse)
      else $error("leading I not decided as zero");

   chk_data_pin_drive: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      rx_mode |-> !o_bidir_data_pin_oe_n &&
                  ($past(i_rise) ? (o_bidir_data_pin == $past(qch_s)) : $stable(o_bidir_data_pin)))
      else $error("data pin not driven in receive");

   chk_clear_on_start: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (state_r == RXC_ST_IDLE && active && !est_restart) |=> (state_r == RXC_ST_COUNT) && (count_r == 8'h00))
      else $error("counter not cleared at start");

   chk_result_latch: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (done && active && !est_restart) |=> (result_r == $past(count_nxt)) && (state_r == RXC_ST_IDLE))
      else $error("result not latched at end");

   chk_hold_inactive: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      !active |=> $stable(result_r) && (state_r == RXC_ST_IDLE))
      else $error("estimator ran while inactive");

   chk_up_nonneg: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (est_mode == RXC_EST_UP && state_r == RXC_ST_COUNT) |-> !count_nxt[7] || count_r[7])
      else $error("up-only count went negative");

   chk_down_step: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (state_r == RXC_ST_COUNT && count_down && count_r != 8'h80 && active && !est_restart)
      |=> count_r == $past(count_r) - 8'h01)
      else $error("down pulse did not decrement");

endmodule // rxc_top

// *** rxc_top_test.sv ***
`timescale 1ns/10ps
`include "rxc_defs.svh"

module rxc_top_test;
   import rxc_pkg::*;
   logic           ref_clk;
   logic           resetn;
   logic           ichan;
   logic           qchan;
   logic           strobe;
   logic           data_drive;
   logic           prog_clk;
   logic           prog_en;
   logic           host_data;
   logic           dev_prog_data;
   logic           prog_oe_n;
   logic           pin_out;
   logic           pin_oe_n;
   logic           tx_data;
   logic [1:0]     xcvr_mode;
   rxc_rx_cfg_type rx_cfg;
   logic [3:0]     filter_phase;
   logic           filter_clk;
   logic           prog_wire;
   logic           pin_wire;
   logic [7:0]     result_exp;
   logic [3:0]     pa;
   int             n;
   int             failures;
   int             tests_run;

   // The device owns the shared wire while its enable is low, the host or bench otherwise
   assign prog_wire = !prog_oe_n ? dev_prog_data : host_data;
   assign pin_wire  = !pin_oe_n ? pin_out : data_drive;

   rxc_top i_rxc_top (
      .i_ref_clk(ref_clk), .i_resetn(resetn), .i_prog_clk(prog_clk), .i_prog_enable(prog_en),
      .i_prog_data(prog_wire), .o_prog_data(dev_prog_data), .o_prog_data_oe_n(prog_oe_n),
      .i_ichan(ichan), .i_qchan(qchan), .i_symbol_strobe(strobe), .i_bidir_data_pin(pin_wire),
      .o_bidir_data_pin(pin_out), .o_bidir_data_pin_oe_n(pin_oe_n), .o_tx_data(tx_data),
      .o_xcvr_mode(xcvr_mode), .o_rx_cfg(rx_cfg), .o_filter_phase(filter_phase),
      .o_filter_clk(filter_clk)
   );

   rxc_host_model i_rxc_host_model (
      .i_ref_clk(ref_clk), .i_prog_data(prog_wire), .o_prog_clk(prog_clk),
      .o_prog_enable(prog_en), .o_prog_data(host_data)
   );

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("BAD at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [6:0] addr, input logic [7:0] data);
      i_rxc_host_model.write_reg(addr, data);
   endtask

   task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
      logic [7:0] v;
      i_rxc_host_model.read_reg(addr, v);
      check(v, exp);
   endtask

   // One symbol: one I rise with Q set for the wanted decision, then the strobe
   task automatic symbol(input logic up, input logic rx);
      qchan = up;
      repeat (2) @(negedge ref_clk);
      ichan = 1'b1;
      repeat (8) @(negedge ref_clk);
      if (rx) begin
         check({7'h0, pin_wire}, {7'h0, up});
      end
      ichan = 1'b0;
      repeat (4) @(negedge ref_clk);
      strobe = 1'b1;
      @(negedge ref_clk);
      strobe = 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask

   // First pass syncs to a change, second counts cycles to the next one
   task automatic gap(input logic ph, output int cnt);
      logic [3:0] s;
      cnt = 0;
      for (int p = 0; p < 2; p++) begin
         s   = ph ? filter_phase : {3'h0, filter_clk};
         cnt = 0;
         while (s === (ph ? filter_phase : {3'h0, filter_clk}) && cnt < 200) begin
            @(negedge ref_clk);
            cnt++;
         end
      end
   endtask

   task automatic est_case(input logic [1:0] mode, input logic [1:0] len, input int nup);
      int cnt;
      cnt = 8 << len;
      wr(`RXC_ADDR_ESTC, {4'h0, len, mode});
      repeat (4) @(negedge ref_clk);
      for (int k = 0; k < cnt - 1; k++) begin
         symbol(k < nup, 1'b1);
      end
      rd_chk(`RXC_ADDR_ESTR, result_exp);
      symbol(cnt - 1 < nup, 1'b1);
      case (mode)
         2'h1: result_exp = 8'(nup);
         2'h2: result_exp = 8'(nup - cnt);
         2'h3: result_exp = 8'(2 * nup - cnt);
         default: result_exp = result_exp;
      endcase
      rd_chk(`RXC_ADDR_ESTR, result_exp);
      $display("test estimator mode %0d length %0d done", mode, cnt);
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // About four times the expected run length
   initial begin
      repeat (40000) @(posedge ref_clk);
      failures++;
      close_out;
   end

   initial begin
      resetn     = 1'b0;
      ichan      = 1'b0;
      qchan      = 1'b0;
      strobe     = 1'b0;
      data_drive = 1'b0;
      failures   = 0;
      tests_run  = 0;
      repeat (4) @(negedge ref_clk);
      check({4'h0, filter_phase}, 8'h01);
      resetn = 1'b1;
      repeat (5) @(negedge ref_clk);
      rd_chk(`RXC_ADDR_MAIN, 8'h00);
      rd_chk(`RXC_ADDR_MODF, 8'h00);
      rd_chk(`RXC_ADDR_FCLK, 8'h84);
      rd_chk(`RXC_ADDR_ESTC, 8'h00);
      rd_chk(`RXC_ADDR_ESTR, 8'h00);
      wr(7'h02, 8'h5A);
      rd_chk(7'h02, 8'h00);
      wr(`RXC_ADDR_ESTC, 8'hF3);
      rd_chk(`RXC_ADDR_ESTC, 8'h03);
      wr(`RXC_ADDR_ESTC, 8'h00);
      $display("test registers done");
      wr(`RXC_ADDR_MAIN, 8'h80);
      check({7'h0, rx_cfg.front_amp_bypass}, 8'h01);
      wr(`RXC_ADDR_MAIN, 8'h00);
      check({7'h0, rx_cfg.front_amp_bypass}, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(`RXC_ADDR_MODF, 8'h08 | 8'(c));
         check({6'h0, rx_cfg.prefilter_corner_sel}, 8'(c));
         check({7'h0, rx_cfg.signal_level_enable}, 8'h01);
      end
      $display("test front end done");
      wr(`RXC_ADDR_FCLK, 8'h45);
      rd_chk(`RXC_ADDR_FCLK, 8'hC5);
      check({7'h0, rx_cfg.filter_clock_double}, 8'h01);
      gap(1'b0, n);
      check(8'(n), 8'h05);
      gap(1'b1, n);
      pa = filter_phase;
      check(8'(n), 8'h05);
      repeat (5) @(negedge ref_clk);
      check({4'h0, filter_phase}, {4'h0, pa[2:0], pa[3]});
      $display("test filter clock done");
      check({7'h0, pin_oe_n}, 8'h01);
      wr(`RXC_ADDR_MAIN, 8'h04);
      check({6'h0, xcvr_mode}, 8'h02);
      check({7'h0, pin_oe_n}, 8'h00);
      symbol(1'b1, 1'b1);
      symbol(1'b0, 1'b1);
      symbol(1'b1, 1'b1);
      $display("test demodulator done");
      result_exp = 8'h00;
      // Combined mode used first, as hosts are expected to prefer it
      est_case(2'h3, 2'h0, 2);
      est_case(2'h1, 2'h1, 5);
      est_case(2'h2, 2'h2, 10);
      est_case(2'h3, 2'h3, 40);
      est_case(2'h0, 2'h0, 3);
      wr(`RXC_ADDR_MAIN, 8'h02);
      wr(`RXC_ADDR_ESTC, 8'h03);
      for (int k = 0; k < 8; k++) begin
         symbol(k < 2, 1'b0);
      end
      rd_chk(`RXC_ADDR_ESTR, result_exp);
      wr(`RXC_ADDR_ESTR, 8'hAA);
      rd_chk(`RXC_ADDR_ESTR, result_exp);
      data_drive = 1'b1;
      repeat (3) @(negedge ref_clk);
      check({7'h0, tx_data}, 8'h01);
      data_drive = 1'b0;
      repeat (3) @(negedge ref_clk);
      check({7'h0, tx_data}, 8'h00);
      $display("test hold outside receive done");
      close_out;
   end
endmodule // rxc_top_test
